// ### tps_cfg.svh
// Purpose: shared constants of the touch sensor serial port
// Assumes: 250 MHz mclk on both ends
// Notes: counts derive from the bit time and clock period
`ifndef TPS_CFG_SVH
`define TPS_CFG_SVH
`define TPS_ADDR_A 7'h4A
`define TPS_ADDR_B 7'h4B
`define TPS_PTR_WRAP 8'h44
`define TPS_PTR_BASE 8'h00
`define TPS_STATUS_REG 8'h00
`define TPS_CLK_NS 4
`define TPS_BIT_NS 2500
`define TPS_QTR_CYC ((`TPS_BIT_NS / 4 + `TPS_CLK_NS - 1) / `TPS_CLK_NS)
`define TPS_FIFO_DEPTH 4
`define TPS_ACK_BIT 4'd8
`endif

// ### tps_pkg.sv
// Purpose: types of the touch sensor serial port
// Assumes: constants come from tps_cfg.svh
// Notes: one state struct per end
`include "tps_cfg.svh"
package tps_pkg;
  typedef enum logic [2:0] {
    DS_IDLE, DS_ADDR, DS_CMD, DS_WDATA, DS_ACK, DS_RDATA, DS_RACK
  } tps_dev_state_t;
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BYTE, HS_STOP} tps_host_state_t;
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] data;
  } tps_word_t;
  typedef struct packed {
    logic scl_m;
    logic sda_m;
    logic scl;
    logic sda;
    logic scl_d;
    logic sda_d;
    tps_dev_state_t st;
    tps_dev_state_t after;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic drive;
    logic irq;
    logic busy;
    logic push;
    tps_word_t word;
  } tps_dev_regs_t;
  typedef struct packed {
    logic sda_m;
    logic sda;
    logic irq_m;
    logic irq;
    tps_host_state_t st;
    logic [2:0] step;
    logic [15:0] tick;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] tx;
    logic [7:0] rx;
    logic rd;
    logic scl_lo;
    logic sda_lo;
    logic read;
    logic [6:0] addr;
    logic [7:0] ptr;
    logic [7:0] data;
    logic [7:0] len;
    logic err;
    logic rd_valid;
    logic done;
  } tps_host_regs_t;
endpackage : tps_pkg

// ### tps_link_if.sv
// Purpose: two-wire bus plus interrupt line between both ends
// Assumes: pull-ups on every line
// Notes: wired-and resolution, no drive means high
`timescale 1ns/10ps
interface tps_link_if;
  logic scl;
  logic sda;
  logic irq_n;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic dev_irq_o;
  logic dev_irq_oe;
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !(host_sda_oe && !host_sda_o) && !(dev_sda_oe && !dev_sda_o);
  assign irq_n = !(dev_irq_oe && !dev_irq_o);
  modport dev (
    input scl, sda,
    output dev_sda_o, dev_sda_oe, dev_irq_o, dev_irq_oe
  );
  modport host (
    input scl, sda, irq_n,
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe
  );
endinterface : tps_link_if

// ### tps_fifo.sv
// Purpose: small flip-flop fifo for received write words
// Assumes: single clock
// Notes: fill refused while full, drain may stall
`timescale 1ns/10ps
`include "tps_cfg.svh"
module tps_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = `TPS_FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import tps_pkg::*;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } tps_fifo_regs_t;
  tps_fifo_regs_t r;
  tps_fifo_regs_t next_r;
  logic push;
  logic pop;
  assign in_ready = r.cnt != (AW+1)'(DEPTH);
  assign out_valid = r.cnt != '0;
  assign out_data = r.mem[r.rd];
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_r = r;
    if (push) begin
      next_r.mem[r.wr] = in_data;
      next_r.wr = (r.wr == AW'(DEPTH - 1)) ? '0 : r.wr + 1'b1;
    end
    if (pop) begin
      next_r.rd = (r.rd == AW'(DEPTH - 1)) ? '0 : r.rd + 1'b1;
    end
    next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule : tps_fifo

// ### tps_dev.sv
// Purpose: slave end of the touch sensor serial port
// Assumes: rd_data answers rd_addr in the same cycle
// Notes: writes leave through a fifo; full fifo refuses the byte
`timescale 1ns/10ps
`include "tps_cfg.svh"
module tps_dev #(
  parameter logic [6:0] DEV_ADDR = `TPS_ADDR_A
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // bus pins
  tps_link_if.dev link,
  // write words toward the register file
  output logic wr_valid,
  input wire logic wr_ready,
  output tps_pkg::tps_word_t wr_word,
  // read port of the register file
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  // electrode status change and port state
  input wire logic status_event,
  output logic irq_pending,
  output logic bus_busy
);
  import tps_pkg::*;
  tps_dev_regs_t r;
  tps_dev_regs_t next_r;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic fifo_ready;
  logic [7:0] ptr_inc;

  // received words wait here so a slow register file can lag four words before a byte is refused
  tps_fifo #(
    .WIDTH($bits(tps_word_t)),
    .DEPTH(`TPS_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_valid(r.push),
    .in_ready(fifo_ready),
    .in_data(r.word),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_word)
  );

  always_comb begin
    next_r = r;
    // pins pass two flops before anything reads them
    next_r.scl_m = link.scl;
    next_r.sda_m = link.sda;
    next_r.scl = r.scl_m;
    next_r.sda = r.sda_m;
    next_r.scl_d = r.scl;
    next_r.sda_d = r.sda;
    next_r.push = 1'b0;
    // clock is only sampled, never driven
    rise = r.scl && !r.scl_d;
    fall = !r.scl && r.scl_d;
    start = r.scl && r.scl_d && r.sda_d && !r.sda;
    stop = r.scl && r.scl_d && !r.sda_d && r.sda;
    if (r.ptr == `TPS_PTR_WRAP) begin
      ptr_inc = `TPS_PTR_BASE;
    end else begin
      ptr_inc = r.ptr + 8'h01;
    end
    if (start) begin
      // a repeated start keeps the pointer
      next_r.st = DS_ADDR;
      next_r.bitn = 4'd0;
      next_r.drive = 1'b0;
      next_r.busy = 1'b1;
    end else if (stop) begin
      // stop after the pointer byte leaves only the pointer
      next_r.st = DS_IDLE;
      next_r.drive = 1'b0;
      next_r.busy = 1'b0;
    end else begin
      case (r.st)
        DS_IDLE: begin
          next_r.drive = 1'b0;
        end
        DS_ADDR, DS_CMD, DS_WDATA: begin
          if (rise) begin
            next_r.sh = {r.sh[6:0], r.sda};
            next_r.bitn = r.bitn + 4'd1;
          end
          if (fall && r.bitn == `TPS_ACK_BIT) begin
            next_r.st = DS_ACK;
            next_r.drive = 1'b1;
            if (r.st == DS_ADDR) begin
              // low direction bit writes, high reads
              next_r.after = r.sh[0] ? DS_RDATA : DS_CMD;
              if (r.sh[7:1] != DEV_ADDR) begin
                next_r.st = DS_IDLE;
                next_r.drive = 1'b0;
              end
            end else if (r.st == DS_CMD) begin
              next_r.ptr = r.sh;
              next_r.after = DS_WDATA;
            end else if (fifo_ready) begin
              // one push at most per byte, so a ready seen here still holds
              next_r.push = 1'b1;
              next_r.word.ptr = r.ptr;
              next_r.word.data = r.sh;
              next_r.ptr = ptr_inc;
              next_r.after = DS_WDATA;
            end else begin
              // no room: not acknowledged, rest of the frame ignored
              next_r.drive = 1'b0;
              next_r.after = DS_IDLE;
            end
          end
        end
        DS_ACK: begin
          // ack held from one falling edge to the next
          if (fall) begin
            next_r.st = r.after;
            next_r.bitn = 4'd0;
            next_r.drive = 1'b0;
            if (r.after == DS_RDATA) begin
              next_r.sh = rd_data;
              next_r.drive = !rd_data[7];
              next_r.ptr = ptr_inc;
              if (r.ptr == `TPS_STATUS_REG) begin
                next_r.irq = 1'b0;
              end
            end
          end
        end
        DS_RDATA: begin
          if (rise) begin
            next_r.bitn = r.bitn + 4'd1;
          end
          // data changes only while clock is low
          if (fall) begin
            if (r.bitn == `TPS_ACK_BIT) begin
              next_r.st = DS_RACK;
              next_r.drive = 1'b0;
            end else begin
              next_r.sh = {r.sh[6:0], 1'b0};
              next_r.drive = !r.sh[6];
            end
          end
        end
        DS_RACK: begin
          if (rise && r.sda) begin
            // master declined: no more bytes, wait for stop or start
            next_r.st = DS_IDLE;
          end else if (fall) begin
            next_r.st = DS_RDATA;
            next_r.bitn = 4'd0;
            next_r.sh = rd_data;
            next_r.drive = !rd_data[7];
            next_r.ptr = ptr_inc;
            if (r.ptr == `TPS_STATUS_REG) begin
              next_r.irq = 1'b0;
            end
          end
        end
        default: begin
          next_r.st = DS_IDLE;
          next_r.drive = 1'b0;
        end
      endcase
    end
    // a change arriving with the clearing read still raises the line
    if (status_event) begin
      next_r.irq = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // open drain: only ever pulls low
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = r.drive;
  assign link.dev_irq_o = 1'b0;
  assign link.dev_irq_oe = r.irq;
  assign rd_addr = r.ptr;
  assign irq_pending = r.irq;
  assign bus_busy = r.busy;
  // sampling at 250 MHz leaves over 150 samples per quarter bit at 400 kbit/s
endmodule : tps_dev

// ### tps_host.sv
// Purpose: master end driving the touch sensor serial port
// Assumes: one command per frame
// Notes: no clock stretching, no arbitration
`timescale 1ns/10ps
`include "tps_cfg.svh"
module tps_host #(
  parameter int QTR = `TPS_QTR_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // bus pins
  tps_link_if.host link,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_ptr,
  input wire logic [7:0] cmd_data,
  input wire logic [7:0] cmd_len,
  // answers
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic done_err,
  output logic irq_seen
);
  import tps_pkg::*;
  tps_host_regs_t r;
  tps_host_regs_t next_r;
  logic qt;

  always_comb begin
    next_r = r;
    next_r.sda_m = link.sda;
    next_r.sda = r.sda_m;
    // stored inverted so a reset reads as no interrupt
    next_r.irq_m = !link.irq_n;
    next_r.irq = r.irq_m;
    next_r.rd_valid = 1'b0;
    next_r.done = 1'b0;
    qt = r.tick == 16'(QTR - 1);
    next_r.tick = qt ? 16'h0000 : r.tick + 16'h0001;
    if (r.st == HS_IDLE) begin
      next_r.tick = 16'h0000;
      next_r.q = 2'd0;
      if (cmd_valid) begin
        // pointer is written afresh by every command
        next_r.st = HS_START;
        next_r.step = 3'd0;
        next_r.read = cmd_read;
        next_r.addr = cmd_addr;
        next_r.ptr = cmd_ptr;
        next_r.data = cmd_data;
        next_r.len = cmd_len;
        next_r.err = 1'b0;
      end
    end else if (qt) begin
      next_r.q = r.q + 2'd1;
      case (r.st)
        HS_START: begin
          case (r.q)
            2'd0: next_r.sda_lo = 1'b0;
            2'd1: next_r.scl_lo = 1'b0;
            2'd2: next_r.sda_lo = 1'b1;
            default: next_r.scl_lo = 1'b1;
          endcase
        end
        HS_BYTE: begin
          case (r.q)
            2'd0: begin
              if (r.bitn != `TPS_ACK_BIT) begin
                next_r.sda_lo = !r.rd && !r.tx[7];
              end else begin
                next_r.sda_lo = r.rd && r.len != 8'd1;
              end
            end
            2'd1: next_r.scl_lo = 1'b0;
            2'd2: begin
              if (r.bitn != `TPS_ACK_BIT) begin
                next_r.rx = {r.rx[6:0], r.sda};
              end else if (!r.rd && r.sda) begin
                next_r.err = 1'b1;
              end
            end
            default: begin
              next_r.scl_lo = 1'b1;
              next_r.tx = {r.tx[6:0], 1'b0};
              next_r.bitn = r.bitn + 4'd1;
            end
          endcase
        end
        HS_STOP: begin
          case (r.q)
            2'd0: next_r.sda_lo = 1'b1;
            2'd1: next_r.scl_lo = 1'b0;
            2'd2: next_r.sda_lo = 1'b0;
            default: begin
              next_r.st = HS_IDLE;
              next_r.done = 1'b1;
            end
          endcase
        end
        default: next_r.st = HS_IDLE;
      endcase
      // a slot ends at its fourth quarter
      if (r.q == 2'd3 && (r.st == HS_START || (r.st == HS_BYTE && r.bitn == `TPS_ACK_BIT))) begin
        next_r.st = HS_BYTE;
        next_r.bitn = 4'd0;
        next_r.rd = 1'b0;
        case (r.step)
          3'd0: begin
            next_r.tx = {r.addr, 1'b0};
            next_r.step = 3'd1;
          end
          3'd1: begin
            next_r.tx = r.ptr;
            next_r.step = 3'd2;
            if (r.err) begin
              next_r.st = HS_STOP;
            end
          end
          3'd2: begin
            next_r.tx = r.data;
            next_r.step = 3'd5;
            if (r.err || (!r.read && r.len == 8'd0)) begin
              next_r.st = HS_STOP;
            end else if (r.read) begin
              // repeated start keeps the bus between pointer and read
              next_r.st = HS_START;
              next_r.step = 3'd3;
            end
          end
          3'd3: begin
            next_r.tx = {r.addr, 1'b1};
            next_r.step = 3'd4;
          end
          3'd4, 3'd6: begin
            next_r.rd = 1'b1;
            next_r.step = 3'd6;
            if (r.step == 3'd6) begin
              next_r.rd_valid = 1'b1;
              next_r.len = r.len - 8'd1;
            end
            if (r.err || r.len == 8'd0 || (r.step == 3'd6 && r.len == 8'd1)) begin
              next_r.st = HS_STOP;
            end
          end
          3'd5: begin
            // later bytes repeat the data into successive registers
            next_r.tx = r.data;
            next_r.len = r.len - 8'd1;
            if (r.err || r.len == 8'd1) begin
              next_r.st = HS_STOP;
            end
          end
          default: next_r.st = HS_STOP;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // quarter time sets the 400 kbit/s bit rate
  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe = r.scl_lo;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = r.sda_lo;
  assign cmd_ready = r.st == HS_IDLE;
  assign rd_valid = r.rd_valid;
  assign rd_data = r.rx;
  assign done = r.done;
  assign done_err = r.err;
  assign irq_seen = r.irq;
endmodule : tps_host

// ### tps_link_props.sv
// Purpose: wire checks between the host end and the device end
// Assumes: host quarter bit of at least 8 and at most 64 mclk cycles
// Notes: decodes the address byte from the wires itself
`timescale 1ns/10ps
module tps_link_props #(
  parameter logic [6:0] DEV_ADDR = 7'h4A
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // bus wires
  input wire logic scl,
  input wire logic sda,
  input wire logic irq_n,
  // drives
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic dev_irq_o,
  input wire logic dev_irq_oe,
  input wire logic host_scl_oe
);
  typedef struct packed {
    logic scl_q;
    logic sda_q;
    logic busy;
    logic foreign;
    logic [3:0] nrise;
    logic [7:0] sh;
  } tps_chk_t;
  tps_chk_t st;
  tps_chk_t next_st;
  logic start;
  logic stop;
  logic rise;
  assign start = scl && st.scl_q && st.sda_q && !sda;
  assign stop = scl && st.scl_q && !st.sda_q && sda;
  assign rise = scl && !st.scl_q;
  always_comb begin
    next_st = st;
    next_st.scl_q = scl;
    next_st.sda_q = sda;
    if (start) begin
      next_st.busy = 1'h1;
      next_st.foreign = 1'h0;
      next_st.nrise = 4'h0;
    end else if (stop) begin
      next_st.busy = 1'h0;
    end else if (rise && st.nrise < 4'h9) begin
      next_st.nrise = st.nrise + 4'h1;
      if (st.nrise < 4'h8) begin
        next_st.sh = {st.sh[6:0], sda};
      end else if (st.sh[7:1] != DEV_ADDR) begin
        next_st.foreign = 1'h1;
      end
    end
  end
  // idle lines at reset, so no false edge right after release
  always_ff @(posedge mclk) begin
    if (srst) begin
      st <= tps_chk_t'{scl_q: 1'h1, sda_q: 1'h1, default: '0};
    end else begin
      st <= next_st;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_start;
    start;
  endsequence
  sequence s_stop;
    stop;
  endsequence
  bus_idle_a: assert property (!st.busy |-> !dev_sda_oe)
    else $error("device drove data outside a frame");
  dev_od_a: assert property (dev_sda_oe |-> !dev_sda_o && !sda)
    else $error("device data not open drain");
  dev_stable_a: assert property (scl && st.scl_q |-> $stable(dev_sda_oe))
    else $error("device data moved while clock high");
  start_clock_a: assert property (s_start |-> ##[1:64] !scl)
    else $error("no clock after start");
  stop_quiet_a: assert property (s_stop |-> !dev_sda_oe [*8])
    else $error("device drove data after stop");
  addr_quiet_a: assert property (rise && st.nrise < 4'h8 |-> !dev_sda_oe)
    else $error("device drove during address bits");
  ack_match_a: assert property (rise && st.nrise == 4'h8 |-> dev_sda_oe == (st.sh[7:1] == DEV_ADDR))
    else $error("address acknowledge wrong");
  foreign_quiet_a: assert property (st.foreign |-> !dev_sda_oe)
    else $error("device drove after foreign address");
  irq_od_a: assert property (dev_irq_oe |-> !dev_irq_o && !irq_n)
    else $error("interrupt line not pulled low");
  reset_free_a: assert property ($fell(srst) |-> !dev_irq_oe && !dev_sda_oe && !host_scl_oe)
    else $error("line driven right after reset");
endmodule : tps_link_props

// ### touch_sensor_i2c_slave_port_tb_top.sv
// Purpose: host end and device end joined, user sides driven
// Assumes: quarter bit of 8 cycles, register file answers addr xor A5
// Notes: write words stay in the fifo until the bench pops them
`timescale 1ns/10ps
module touch_sensor_i2c_slave_port_tb_top;
  import tps_pkg::*;
  typedef struct packed {
    logic rd;
    logic [7:0] ptr;
    logic [7:0] data;
    logic [7:0] len;
  } tps_row_t;
  localparam tps_row_t ROWS [5] = '{'{1'h0, 8'h10, 8'h55, 8'h01},
    '{1'h0, 8'h44, 8'hAA, 8'h02}, '{1'h0, 8'h20, 8'h00, 8'h00},
    '{1'h1, 8'h10, 8'h00, 8'h02}, '{1'h1, 8'h43, 8'h00, 8'h03}};
  logic mclk = 1'h0;
  logic srst = 1'h1;
  logic cmd_valid = 1'h0;
  logic cmd_read = 1'h0;
  logic [6:0] cmd_addr = 7'h4A;
  logic [7:0] cmd_ptr = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic [7:0] cmd_len = 8'h00;
  logic wr_ready = 1'h0;
  logic status_event = 1'h0;
  logic cmd_ready;
  logic rd_valid;
  logic [7:0] rd_data;
  logic done;
  logic done_err;
  logic irq_seen;
  logic wr_valid;
  tps_word_t wr_word;
  logic [7:0] rd_addr;
  logic [7:0] reg_data;
  logic irq_pending;
  logic bus_busy;
  logic err;
  logic busy_seen;
  logic [7:0] got [$];
  int miscompares = 0;
  int n_checks = 0;
  always #2 mclk = ~mclk;
  assign reg_data = rd_addr ^ 8'hA5;
  tps_link_if link ();
  tps_host #(.QTR(8)) i_tps_host (.mclk(mclk), .srst(srst), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
    .cmd_ptr(cmd_ptr), .cmd_data(cmd_data), .cmd_len(cmd_len), .rd_valid(rd_valid),
    .rd_data(rd_data), .done(done), .done_err(done_err), .irq_seen(irq_seen));
  tps_dev i_tps_dev (.mclk(mclk), .srst(srst), .link(link), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_word(wr_word), .rd_addr(rd_addr), .rd_data(reg_data),
    .status_event(status_event), .irq_pending(irq_pending), .bus_busy(bus_busy));
  tps_link_props i_tps_link_props (.mclk(mclk), .srst(srst), .scl(link.scl), .sda(link.sda),
    .irq_n(link.irq_n), .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
    .dev_irq_o(link.dev_irq_o), .dev_irq_oe(link.dev_irq_oe), .host_scl_oe(link.host_scl_oe));
  function automatic logic [7:0] nxt(input logic [7:0] p);
    return (p == 8'h44) ? 8'h00 : p + 8'h01;
  endfunction : nxt
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // one frame; ready is sampled before the edge that takes the command
  task automatic run_cmd(input logic rd, input logic [6:0] a, input logic [7:0] p,
      input logic [7:0] d, input logic [7:0] n);
    int i;
    got.delete();
    busy_seen = 1'h0;
    cmd_read = rd;
    cmd_addr = a;
    cmd_ptr = p;
    cmd_data = d;
    cmd_len = n;
    cmd_valid = 1'h1;
    for (i = 0; i < 50 && cmd_ready !== 1'h1; i++) tick(1);
    if (cmd_ready !== 1'h1) begin
      miscompares++;
      $display("mismatch at %0t: command never taken", $time);
      finish_test();
    end
    tick(1);
    cmd_valid = 1'h0;
    for (i = 0; i < 4000 && done !== 1'h1; i++) begin
      tick(1);
      if (rd_valid === 1'h1) got.push_back(rd_data);
      if (bus_busy === 1'h1) busy_seen = 1'h1;
    end
    if (done !== 1'h1) begin
      miscompares++;
      $display("mismatch at %0t: frame never ended", $time);
      finish_test();
    end
    err = done_err;
    tick(2);
  endtask : run_cmd
  task automatic pop(input logic [15:0] exp);
    int i;
    for (i = 0; i < 100 && wr_valid !== 1'h1; i++) tick(1);
    check({wr_valid, wr_word}, {1'h1, exp});
    wr_ready = 1'h1;
    tick(1);
    wr_ready = 1'h0;
    tick(1);
  endtask : pop
  initial begin
    int i;
    int k;
    logic [7:0] p;
    tick(16);
    srst = 1'h0;
    tick(3);
    check({link.scl, link.sda, link.irq_n, cmd_ready, wr_valid, irq_pending, rd_addr}, 14'h3C00);
    for (i = 0; i < 5; i++) begin
      run_cmd(ROWS[i].rd, 7'h4A, ROWS[i].ptr, ROWS[i].data, ROWS[i].len);
      check({err, bus_busy}, 2'h0);
      check(busy_seen, 1'h1);
      if (ROWS[i].rd) begin
        p = ROWS[i].ptr;
        check(8'(got.size()), ROWS[i].len);
        for (k = 0; k < got.size(); k++) begin
          check(got[k], p ^ 8'hA5);
          p = nxt(p);
        end
      end else if (ROWS[i].len == 8'h00) begin
        check({wr_valid, rd_addr}, {1'h0, ROWS[i].ptr});
      end else begin
        p = ROWS[i].ptr;
        for (k = 0; k < ROWS[i].len; k++) begin
          pop({p, ROWS[i].data});
          p = nxt(p);
        end
        check(rd_addr, p);
      end
      $display("test row %0d done", i);
    end
    p = rd_addr;
    run_cmd(1'h0, 7'h4B, 8'h30, 8'h66, 8'h01);
    check({err, wr_valid, rd_addr}, {2'h2, p});
    $display("test foreign address done");
    // fifo stalls: four words fit, the fifth is refused
    for (i = 0; i < 5; i++) begin
      run_cmd(1'h0, 7'h4A, 8'h01 + 8'(i), 8'hC0 + 8'(i), 8'h01);
      check(err, i == 4);
    end
    for (i = 0; i < 4; i++) pop({8'h01 + 8'(i), 8'hC0 + 8'(i)});
    check(wr_valid, 1'h0);
    $display("test fifo full done");
    status_event = 1'h1;
    tick(1);
    status_event = 1'h0;
    for (i = 0; i < 20 && irq_seen !== 1'h1; i++) tick(1);
    check({irq_seen, irq_pending, link.irq_n}, 3'h6);
    run_cmd(1'h1, 7'h4A, 8'h00, 8'h00, 8'h01);
    tick(4);
    check({irq_seen, irq_pending, link.irq_n, got[0]}, {3'h1, 8'hA5});
    $display("test interrupt done");
    // second reset with an interrupt freshly raised
    status_event = 1'h1;
    tick(1);
    status_event = 1'h0;
    srst = 1'h1;
    tick(3);
    srst = 1'h0;
    tick(1);
    check({irq_seen, link.irq_n, irq_pending, rd_addr}, 11'h200);
    tick(2);
    run_cmd(1'h1, 7'h4A, 8'h10, 8'h00, 8'h01);
    check({err, 8'(got.size())}, 9'h001);
    check(got[0], 8'h10 ^ 8'hA5);
    $display("test second reset done");
    finish_test();
  end
endmodule : touch_sensor_i2c_slave_port_tb_top
